/* File: rtl/eirq_ctrl.sv */
// External pin request logic with sleep control and Avalon-MM slave
`timescale 1ns/1ps
`include "eirq_params.svh"

// How it works
// - Selected edge on request-1 pin sets flag bit 7.
// - Request-1 vector taken only with flag (or pin low under low sense), global enable and mask bit set.
// - Flag clears on vector entry or when software writes a one.
// - Flag held at zero while request 1 senses low level.
// - Request-1 sense: 00 low, 01 reserved, 10 falling, 11 rising.
// - Request-0 sense uses the same encoding.
// - Pins are synchronised to the clock before edge detection.
// - Enabled low level requests continuously while the pin is low.
// - Sleep instruction sleeps only when sleep enable bit 5 is one.
// - Bit 4 picks idle when zero, power-down when one.
// - Request-1 enable is mask bit 7, vector two above reset.
// - Request-0 enable is mask bit 6, vector one above reset.
// - Pin activity requests even when the pin drives as output.
module eirq_ctrl (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ext_request1,
  input wire logic ext_request0,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  output logic cpu_int_req,
  output logic [7:0] cpu_vector,
  output logic sleep_idle,
  output logic sleep_power_down
);

  // ==========================================================
  // Declarations
  logic sync1_meta;
  logic sync1;
  logic sync0_meta;
  logic sync0;
  logic prev1;
  logic prev0;
  logic [7:0] ext_request_mask;
  logic [7:0] ext_request_flags;
  logic [7:0] sleep_and_sense_control;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic cpu_status_word;
  eirq_pkg::eirq_power_t power;
  eirq_pkg::eirq_sense_t sense1;
  eirq_pkg::eirq_sense_t sense0;
  logic hit1;
  logic hit0;
  logic active1;
  logic active0;
  logic take1;
  logic take0;
  logic ack_pulse;
  logic sleep_cmd;
  logic done;
  logic wr_ok;
  logic rd_ok;
  logic wr_flags;
  logic [7:0] next_flags;
  logic [31:0] next_rdata;

  // ==========================================================
  // Two-flop pin synchronisers, pin sampled whatever its direction
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1_meta <= 1'b1;
      sync0_meta <= 1'b1;
      sync1 <= 1'b1;
      sync0 <= 1'b1;
    end else begin
      sync1_meta <= ext_request1;
      sync0_meta <= ext_request0;
      sync1 <= sync1_meta;
      sync0 <= sync0_meta;
    end
  end

  // Previous sample for edge detection
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prev1 <= 1'h1;
      prev0 <= 1'h1;
    end else begin
      prev1 <= sync1;
      prev0 <= sync0;
    end
  end

  // ==========================================================
  // Trigger decode
  assign sense1 = eirq_pkg::eirq_sense_t'(sleep_and_sense_control[
    `EIRQ_BIT_SENSE1_HI:`EIRQ_BIT_SENSE1_LO]);
  assign sense0 = eirq_pkg::eirq_sense_t'(sleep_and_sense_control[
    `EIRQ_BIT_SENSE0_HI:`EIRQ_BIT_SENSE0_LO]);

  // Edge hits per selected sense; reserved gives nothing
  always_comb begin
    hit1 = 1'b0;
    hit0 = 1'b0;
    case (sense1)
      eirq_pkg::eirq_sense_fall: hit1 = prev1 & ~sync1;
      eirq_pkg::eirq_sense_rise: hit1 = ~prev1 & sync1;
      default: hit1 = 1'b0;
    endcase
    case (sense0)
      eirq_pkg::eirq_sense_fall: hit0 = prev0 & ~sync0;
      eirq_pkg::eirq_sense_rise: hit0 = ~prev0 & sync0;
      default: hit0 = 1'b0;
    endcase
  end

  // Request active: stored flag, or live low level
  assign active1 = (sense1 == eirq_pkg::eirq_sense_low) ? ~sync1 :
    ext_request_flags[`EIRQ_BIT_REQ1];
  assign active0 = (sense0 == eirq_pkg::eirq_sense_low) ? ~sync0 :
    ext_request_flags[`EIRQ_BIT_REQ0];

  // Enabled requests; request 1 wins when vector is chosen
  assign take1 = active1 & cpu_status_word & ext_request_mask[`EIRQ_BIT_REQ1];
  assign take0 = active0 & cpu_status_word & ext_request_mask[`EIRQ_BIT_REQ0];

  // ==========================================================
  // Bus decode, one wait cycle on each access
  assign done = (avs_read | avs_write) & avs_waitrequest;
  assign wr_ok = avs_write & done & avs_byteenable[0];
  assign rd_ok = avs_read & done;
  assign wr_flags = wr_ok & (avs_address == `EIRQ_IDX_FLAGS);
  assign ack_pulse = wr_ok & (avs_address == `EIRQ_IDX_CPU) &
    avs_writedata[`EIRQ_BIT_CPU_ACK];
  assign sleep_cmd = wr_ok & (avs_address == `EIRQ_IDX_CPU) &
    avs_writedata[`EIRQ_BIT_CPU_SLEEP];

  // Waitrequest high until the access completes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
    end
  end

  // ==========================================================
  // Flag register: set wins over clear
  always_comb begin
    next_flags = ext_request_flags;
    if (wr_flags) begin
      next_flags = next_flags & ~avs_writedata[7:0];
    end
    if (ack_pulse & take1) begin
      next_flags[`EIRQ_BIT_REQ1] = 1'b0;
    end
    if (ack_pulse & take0 & ~take1) begin
      next_flags[`EIRQ_BIT_REQ0] = 1'b0;
    end
    if (hit1) begin
      next_flags[`EIRQ_BIT_REQ1] = 1'b1;
    end
    if (hit0) begin
      next_flags[`EIRQ_BIT_REQ0] = 1'b1;
    end
    if (sense1 == eirq_pkg::eirq_sense_low) begin
      next_flags[`EIRQ_BIT_REQ1] = 1'b0;
    end
    if (sense0 == eirq_pkg::eirq_sense_low) begin
      next_flags[`EIRQ_BIT_REQ0] = 1'b0;
    end
    next_flags = next_flags & `EIRQ_MASK_USED;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ext_request_flags <= `EIRQ_RST_BYTE;
    end else begin
      ext_request_flags <= next_flags;
    end
  end

  // ==========================================================
  // Software registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ext_request_mask <= `EIRQ_RST_BYTE;
      sleep_and_sense_control <= `EIRQ_RST_BYTE;
      irq_mask <= 2'h0;
      cpu_status_word <= 1'b0;
    end else if (wr_ok) begin
      case (avs_address)
        `EIRQ_IDX_MASK: ext_request_mask <= avs_writedata[7:0] & `EIRQ_MASK_USED;
        `EIRQ_IDX_CTRL: sleep_and_sense_control <= avs_writedata[7:0];
        `EIRQ_IDX_IRQ_MASK: irq_mask <= avs_writedata[`EIRQ_BIT_REQ1:`EIRQ_BIT_REQ0];
        `EIRQ_IDX_CPU: cpu_status_word <= avs_writedata[`EIRQ_BIT_CPU_GIE];
        default: ;
      endcase
    end
  end

  // Sticky event status, cleared by read; new event wins
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_status <= 2'h0;
    end else begin
      irq_status <= ((rd_ok && avs_address == `EIRQ_IDX_IRQ_STATUS) ? 2'h0 : irq_status)
        | {hit1, hit0};
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // ==========================================================
  // Request and vector to the core
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cpu_int_req <= 1'b0;
      cpu_vector <= `EIRQ_RESET_VECTOR;
    end else begin
      cpu_int_req <= take1 | take0;
      if (take1) begin
        cpu_vector <= `EIRQ_VEC_REQ1;
      end else if (take0) begin
        cpu_vector <= `EIRQ_VEC_REQ0;
      end else begin
        cpu_vector <= `EIRQ_RESET_VECTOR;
      end
    end
  end

  // ==========================================================
  // Sleep control; a taken request wakes the core
  always_ff @(posedge clk) begin
    if (!nrst) begin
      power <= eirq_pkg::eirq_run;
    end else begin
      case (power)
        eirq_pkg::eirq_run: begin
          if (sleep_cmd && sleep_and_sense_control[`EIRQ_BIT_SLEEP_EN]) begin
            power <= sleep_and_sense_control[`EIRQ_BIT_SLEEP_TYPE] ?
              eirq_pkg::eirq_power_down : eirq_pkg::eirq_idle;
          end
        end
        eirq_pkg::eirq_idle, eirq_pkg::eirq_power_down: begin
          if (take1 | take0) begin
            power <= eirq_pkg::eirq_run;
          end
        end
        default: power <= eirq_pkg::eirq_run;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sleep_idle <= 1'b0;
      sleep_power_down <= 1'b0;
    end else begin
      sleep_idle <= (power == eirq_pkg::eirq_idle);
      sleep_power_down <= (power == eirq_pkg::eirq_power_down);
    end
  end

  // ==========================================================
  // Read data, registered at the completing edge
  always_comb begin
    next_rdata = `EIRQ_RDATA_ZERO;
    case (avs_address)
      `EIRQ_IDX_MASK: next_rdata[7:0] = ext_request_mask;
      `EIRQ_IDX_FLAGS: next_rdata[7:0] = ext_request_flags;
      `EIRQ_IDX_CTRL: next_rdata[7:0] = sleep_and_sense_control;
      `EIRQ_IDX_IRQ_STATUS: next_rdata[`EIRQ_BIT_REQ1:`EIRQ_BIT_REQ0] = irq_status;
      `EIRQ_IDX_IRQ_MASK: next_rdata[`EIRQ_BIT_REQ1:`EIRQ_BIT_REQ0] = irq_mask;
      `EIRQ_IDX_CPU: next_rdata[`EIRQ_BIT_CPU_GIE] = cpu_status_word;
      `EIRQ_IDX_VECTOR: next_rdata[7:0] = cpu_vector;
      default: next_rdata = `EIRQ_RDATA_ZERO;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      avs_readdata <= `EIRQ_RDATA_ZERO;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= next_rdata;
    end
  end

endmodule

/* File: rtl/eirq_params.svh */
// Register offsets, field positions and reset values for the external request block
`ifndef EIRQ_PARAMS_SVH
`define EIRQ_PARAMS_SVH

// ==========================================================
// Register word offsets (byte address = 4 * index)
`define EIRQ_IDX_MASK 3'h0
`define EIRQ_IDX_FLAGS 3'h1
`define EIRQ_IDX_CTRL 3'h2
`define EIRQ_IDX_IRQ_STATUS 3'h3
`define EIRQ_IDX_IRQ_MASK 3'h4
`define EIRQ_IDX_CPU 3'h5
`define EIRQ_IDX_VECTOR 3'h6

// ==========================================================
// Field positions
`define EIRQ_BIT_REQ1 7
`define EIRQ_BIT_REQ0 6
`define EIRQ_BIT_SLEEP_EN 5
`define EIRQ_BIT_SLEEP_TYPE 4
`define EIRQ_BIT_SENSE1_HI 3
`define EIRQ_BIT_SENSE1_LO 2
`define EIRQ_BIT_SENSE0_HI 1
`define EIRQ_BIT_SENSE0_LO 0
`define EIRQ_BIT_CPU_GIE 0
`define EIRQ_BIT_CPU_SLEEP 1
`define EIRQ_BIT_CPU_ACK 2

// ==========================================================
// Reset values and vectors
`define EIRQ_RST_BYTE 8'h00
`define EIRQ_MASK_USED 8'hc0
`define EIRQ_RESET_VECTOR 8'h00
`define EIRQ_VEC_REQ0 8'h01
`define EIRQ_VEC_REQ1 8'h02
`define EIRQ_RDATA_ZERO 32'h0000_0000

`endif

/* File: rtl/eirq_pkg.sv */
// Types shared by the external request block
package eirq_pkg;

  // ==========================================================
  // Sense encodings
  typedef enum logic [1:0] {
    eirq_sense_low = 2'h0,
    eirq_sense_rsvd = 2'h1,
    eirq_sense_fall = 2'h2,
    eirq_sense_rise = 2'h3
  } eirq_sense_t;

  // Power state
  typedef enum logic [1:0] {
    eirq_run,
    eirq_idle,
    eirq_power_down
  } eirq_power_t;

endpackage

/* File: testbench/eirq_ctrl_props.sv */
// Port checker for the external request block
`timescale 1ns/1ps
module eirq_ctrl_props (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irq,
  input wire logic cpu_int_req,
  input wire logic [7:0] cpu_vector,
  input wire logic sleep_idle,
  input wire logic sleep_power_down
);
  // ==========================================
  // Clocking and helpers
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  wire rd_done = avs_read && !avs_waitrequest;

  // ==========================================
  // Properties
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait low too long");
  property p_wait_cause;
    $fell(avs_waitrequest) |-> $past(avs_read || avs_write);
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
  property p_mask_rsvd;
    rd_done && avs_address == 3'h0 |-> avs_readdata[5:0] == 6'h00;
  endproperty
  a_mask_rsvd: assert property (p_mask_rsvd) else $error("mask low bits set");
  property p_unmapped;
    rd_done && avs_address == 3'h7 |-> avs_readdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_vec;
    cpu_int_req |-> cpu_vector inside {8'h01, 8'h02};
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_sleep_excl;
    !(sleep_idle && sleep_power_down);
  endproperty
  a_sleep_excl: assert property (p_sleep_excl) else $error("two sleep kinds");
  property p_sleep_cause;
    $rose(sleep_idle || sleep_power_down) |->
      $past(avs_write, 2) || $past(avs_write, 3) || $past(avs_write, 4);
  endproperty
  a_sleep_cause: assert property (p_sleep_cause) else $error("sleep without command");
  property p_irq_clr;
    rd_done && avs_address == 3'h3 |-> ##2 !irq;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("irq kept after read");
  property p_rst;
    disable iff (1'b0) !nrst |=> avs_waitrequest && !irq && !cpu_int_req && !sleep_idle;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");

  // Main scenarios seen
  c_pd: cover property (sleep_power_down);
  c_req0: cover property (cpu_int_req && cpu_vector == 8'h01);
  c_irq: cover property ($fell(irq));
endmodule

bind eirq_ctrl eirq_ctrl_props u_eirq_ctrl_props (.clk(clk), .nrst(nrst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
  .cpu_int_req(cpu_int_req), .cpu_vector(cpu_vector), .sleep_idle(sleep_idle),
  .sleep_power_down(sleep_power_down));

/* File: testbench/eirq_ctrl_tb_top.sv */
// Self-checking bench for the external request block
`timescale 1ns/1ps
module eirq_ctrl_tb_top;
  logic clk, ext_request1, ext_request0, avs_waitrequest, irq, cpu_int_req;
  logic sleep_idle, sleep_power_down;
  logic nrst = 1'b0, lvl1 = 1'b1, lvl0 = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [2:0] avs_address = 3'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [3:0] avs_byteenable = 4'hf;
  logic [7:0] cpu_vector;
  int errors = 0, checked = 0, cycles = 0, m, e;
  integer seed;

  // ==========================================
  // Clock, timeout and instances
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end
  eirq_pin_model u_eirq_pin_model (.clk(clk), .lvl1(lvl1), .lvl0(lvl0),
    .ext_request1(ext_request1), .ext_request0(ext_request0));
  eirq_ctrl u_eirq_ctrl (.clk(clk), .nrst(nrst), .ext_request1(ext_request1),
    .ext_request0(ext_request0), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .cpu_int_req(cpu_int_req), .cpu_vector(cpu_vector), .sleep_idle(sleep_idle),
    .sleep_power_down(sleep_power_down));

  // ==========================================
  // Tasks
  task conclude();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    avs_read <= ~w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= {24'($random(seed)), d};
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task pins(input logic v);
    lvl1 <= v;
    lvl0 <= v;
    repeat (8 + ($random(seed) & 3)) @(posedge clk);
  endtask
  task reset();
    nrst <= 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
  endtask

  // ==========================================
  // Main sequence
  initial begin
    seed = 32'h1f83;
    @(posedge clk);
    reset();
    for (int a = 0; a < 8; a++) begin
      bus(1'b0, 3'(a), 8'h00);
      chk(q, 0);
    end
    // Only the enables stick; a write without its byte lane is dropped
    bus(1'b1, 3'h0, 8'hff);
    avs_byteenable <= 4'he;
    bus(1'b1, 3'h0, 8'h00);
    avs_byteenable <= 4'hf;
    bus(1'b0, 3'h0, 8'h00);
    chk(q, 32'hc0);
    bus(1'b1, 3'h4, 8'hc0);
    bus(1'b1, 3'h5, 8'h01);
    // Every sense code on both pins, low phase then high phase
    for (m = 0; m < 4; m++) begin
      bus(1'b1, 3'h2, 8'(m * 5));
      pins(1'b0);
      chk(cpu_int_req, m == 0 || m == 2);
      bus(1'b0, 3'h1, 8'h00);
      chk(q, m == 2 ? 32'hc0 : 0);
      pins(1'b1);
      e = m >= 2 ? 32'hc0 : 0;
      chk(irq, e != 0);
      chk(cpu_vector, e != 0 ? 2 : 0);
      bus(1'b0, 3'h3, 8'h00);
      chk(q, e);
      bus(1'b0, 3'h1, 8'h00);
      chk(q, e);
      if (e != 0) begin
        bus(1'b1, 3'h5, 8'h00);
        chk(cpu_int_req, 0);
        // Ack only clears a request that is being taken, so enable first
        bus(1'b1, 3'h5, 8'h01);
        chk(cpu_int_req, 1);
        bus(1'b1, 3'h5, 8'h05);
        chk(cpu_vector, 1);
        bus(1'b1, 3'h1, 8'h40);
        chk(cpu_int_req, 0);
      end
    end
    // Masked edge stays quiet until unmasked
    bus(1'b1, 3'h4, 8'h00);
    pins(1'b0);
    pins(1'b1);
    chk(irq, 0);
    bus(1'b1, 3'h4, 8'hc0);
    chk(irq, 1);
    bus(1'b0, 3'h3, 8'h00);
    chk(q, 32'hc0);
    chk(irq, 0);
    // Sleep only with its enable set; bit 4 picks the kind
    for (m = 0; m < 3; m++) begin
      reset();
      bus(1'b1, 3'h2, 8'(m == 0 ? 0 : 16 * m + 16));
      bus(1'b1, 3'h5, 8'h02);
      chk(sleep_idle, m == 1);
      chk(sleep_power_down, m == 2);
    end
    conclude();
  end
endmodule

/* File: testbench/eirq_pin_model.sv */
// Board-side driver of the two request pins
`timescale 1ns/1ps
module eirq_pin_model (
  input wire logic clk,
  input wire logic lvl1,
  input wire logic lvl0,
  output logic ext_request1 = 1'b1,
  output logic ext_request0 = 1'b1
);
  // Pins move just after an edge and hold whole cycles
  always @(posedge clk) begin
    ext_request1 <= lvl1;
    ext_request0 <= lvl0;
  end
endmodule
